// ---- pkg/temp_conv_map.svh ----
`ifndef TEMP_CONV_MAP_SVH
`define TEMP_CONV_MAP_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define SYS_CLK_KHZ 50000
`define TIMEOUT_MS 25
`define POR_MS 1
`define CONV11_MS 14
`define CONV12_MS 28
`define CONV13_MS 56
`define CONV14_MS 112
`define CNT_W 23

// ----------------------------------------
// Result register layout and reset values
// ----------------------------------------
`define TEMP_W 16
`define TEMP_SIGN_BIT 15
`define TEMP_RESET_VALUE 16'h0000
`define TEMP_PENDING_VALUE 16'h8000
`define RES_RESET_VALUE 2'h0
`define MASK_RES11 16'hFFE0
`define MASK_RES12 16'hFFF0
`define MASK_RES13 16'hFFF8
`define MASK_RES14 16'hFFFC
`define LINK_BITS 5'h10

`endif

// ---- pkg/temp_conv_pkg.sv ----
`include "temp_conv_map.svh"

package temp_conv_pkg;

   typedef enum logic [1:0] {
      ST_POWER_UP,
      ST_CONVERT,
      ST_STANDBY,
      ST_ONE_SHOT
   } conv_state_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } bus_pins_t;

   typedef struct packed {
      logic [`TEMP_W-1:0] word;
      logic               ready;
   } result_t;

   typedef struct packed {
      bus_pins_t          meta;
      bus_pins_t          sync;
      bus_pins_t          prev;
      logic               frame;
      logic [`CNT_W-1:0]  idle_cnt;
      logic [`TEMP_W-1:0] snap;
      conv_state_t        st;
      logic [`CNT_W-1:0]  cnt;
      logic [1:0]         res_lat;
      logic               functional;
      result_t            res;
      logic               sda_out;
   } core_state_t;

   typedef struct packed {
      logic [4:0] bit_cnt;
      logic       oe;
   } link_state_t;

endpackage

// ---- src/serial_shift_out.sv ----
`timescale 1ns/100ps
`include "temp_conv_map.svh"

// ----------------------------------------
// Link-clock side: shifts the frozen word out
// ----------------------------------------
module serial_shift_out (
   input  wire logic               smb_clk,
   input  wire logic               link_rst_n,
   input  wire logic [`TEMP_W-1:0] word,
   output logic                    sda_oe
);

   temp_conv_pkg::link_state_t q;
   temp_conv_pkg::link_state_t d;

   // Word is held still by the core for the whole frame
   always_comb begin
      d = q;
      if (q.bit_cnt < `LINK_BITS) begin
         d.oe = ~word[4'(`TEMP_SIGN_BIT - q.bit_cnt)];
         d.bit_cnt = q.bit_cnt + 5'h1;
      end else begin
         d.oe = 1'b0;
      end
   end

   // Frame end or bus timeout clears this side without any clock edge
   always_ff @(negedge smb_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign sda_oe = q.oe;

endmodule // serial_shift_out

// ---- src/temp_sensor_conversion_core.sv ----
`timescale 1ns/100ps
`include "temp_conv_map.svh"

// Operation
// [RULE1] Line low past timeout: idle, release lines
// [RULE2] Serial side live within 1 ms
// [RULE3] First result one conversion after live
// [RULE4] Reset values hold until first conversion
// [RULE5] Shutdown one-shot runs exactly one conversion
// [RULE6] One-shot pending: flag zero, result 8000h
// [RULE7] One-shot leaves other state untouched
// [RULE8] One-shot done: flag set, result loaded
// [RULE9] Two-bit field selects 11 to 14 bits
// [RULE10] Reset resolution is 11 bits
// [RULE11] Result is two's complement
// [RULE12] Result left-justified, sign in top bit
// [RULE13] Bits below resolution read zero
// [RULE14] Result readable anytime, last completed value
// [RULE15] One-shot ignored outside shutdown
module temp_sensor_conversion_core #(
   parameter int unsigned ADC_W       = 14,
   parameter int unsigned TIMEOUT_CYC = `TIMEOUT_MS * `SYS_CLK_KHZ,
   parameter int unsigned POR_CYC     = `POR_MS * `SYS_CLK_KHZ,
   parameter int unsigned CONV11_CYC  = `CONV11_MS * `SYS_CLK_KHZ,
   parameter int unsigned CONV12_CYC  = `CONV12_MS * `SYS_CLK_KHZ,
   parameter int unsigned CONV13_CYC  = `CONV13_MS * `SYS_CLK_KHZ,
   parameter int unsigned CONV14_CYC  = `CONV14_MS * `SYS_CLK_KHZ
) (
   input  wire logic               sys_clk,
   input  wire logic               resetn,
   input  wire logic               smb_clk,
   input  wire logic               scl_in,
   input  wire logic               sda_in,
   output logic                    sda_out,
   output logic                    sda_oe,
   input  wire logic               shutdown,
   input  wire logic               one_shot_req,
   input  wire logic               resolution_select_high,
   input  wire logic               resolution_select_low,
   input  wire logic [ADC_W-1:0]   adc_code,
   output logic [`TEMP_W-1:0]      temperature_result,
   output logic                    result_ready_flag,
   output logic                    link_functional
);

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic [1:0] rst_sync_q;
   logic       rst_n;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_q[1];

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [`TEMP_W-1:0] res_mask(input logic [1:0] r);
      case (r)
         2'h0:    res_mask = `MASK_RES11;
         2'h1:    res_mask = `MASK_RES12;
         2'h2:    res_mask = `MASK_RES13;
         default: res_mask = `MASK_RES14;
      endcase
   endfunction

   function automatic logic [`CNT_W-1:0] conv_last(input logic [1:0] r);
      case (r)
         2'h0:    conv_last = `CNT_W'(CONV11_CYC - 1);
         2'h1:    conv_last = `CNT_W'(CONV12_CYC - 1);
         2'h2:    conv_last = `CNT_W'(CONV13_CYC - 1);
         default: conv_last = `CNT_W'(CONV14_CYC - 1);
      endcase
   endfunction

   temp_conv_pkg::core_state_t q;
   temp_conv_pkg::core_state_t d;

   logic [1:0]         res_sel;
   logic [`TEMP_W-1:0] formatted;
   logic               conv_done;

   assign res_sel = {resolution_select_high, resolution_select_low};
   // Code is two's complement already; shift up so its sign is bit 15
   assign formatted = {adc_code, {(`TEMP_W - ADC_W){1'b0}}}
                      & res_mask(q.res_lat); // [RULE11] [RULE12] [RULE13]
   assign conv_done = (q.st == temp_conv_pkg::ST_CONVERT ||
                       q.st == temp_conv_pkg::ST_ONE_SHOT) &&
                      q.cnt == conv_last(q.res_lat);

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic start_ev;
      logic stop_ev;
      logic line_low;
      start_ev = 1'b0;
      stop_ev  = 1'b0;
      line_low = 1'b0;
      d = q;

      d.meta = '{scl: scl_in, sda: sda_in};
      d.sync = q.meta;
      d.prev = q.sync;
      start_ev = q.prev.sda & ~q.sync.sda & q.prev.scl & q.sync.scl;
      stop_ev  = ~q.prev.sda & q.sync.sda & q.prev.scl & q.sync.scl;
      line_low = ~q.sync.scl | ~q.sync.sda;

      // Frame tracking; word frozen at start so the link sees it steady
      if (start_ev && q.functional) begin
         d.frame = 1'b1;
         d.snap  = q.res.word; // [RULE14]
      end
      if (stop_ev) begin
         d.frame = 1'b0;
      end

      // Stuck bus: counter saturates so a held line keeps us idle
      if (line_low) begin
         if (q.idle_cnt == `CNT_W'(TIMEOUT_CYC - 1)) begin
            d.frame = 1'b0; // [RULE1]
         end else begin
            d.idle_cnt = q.idle_cnt + `CNT_W'(1);
         end
      end else begin
         d.idle_cnt = '0;
      end

      case (q.st)
         temp_conv_pkg::ST_POWER_UP: begin
            // Registers keep reset values through this wait
            // Reset sync cycles count against the 1 ms budget
            if (q.cnt == `CNT_W'(POR_CYC - 3)) begin
               d.functional = 1'b1; // [RULE2]
               d.cnt        = '0;
               d.res_lat    = res_sel;
               d.st         = temp_conv_pkg::ST_CONVERT; // [RULE3]
            end else begin
               d.cnt = q.cnt + `CNT_W'(1); // [RULE4]
            end
         end
         temp_conv_pkg::ST_CONVERT: begin
            // A one-shot request here has no effect
            if (conv_done) begin
               d.res.word  = formatted; // [RULE3]
               d.res.ready = 1'b1;
               d.cnt       = '0;
               d.res_lat   = res_sel; // [RULE9]
               if (shutdown) begin
                  d.st = temp_conv_pkg::ST_STANDBY;
               end
            end else begin
               d.cnt = q.cnt + `CNT_W'(1); // [RULE15]
            end
         end
         temp_conv_pkg::ST_STANDBY: begin
            d.cnt     = '0;
            d.res_lat = res_sel;
            if (!shutdown) begin
               d.st = temp_conv_pkg::ST_CONVERT;
            end else if (one_shot_req) begin
               d.res.word  = `TEMP_PENDING_VALUE; // [RULE6]
               d.res.ready = 1'b0; // [RULE6]
               d.st        = temp_conv_pkg::ST_ONE_SHOT; // [RULE5]
            end
         end
         temp_conv_pkg::ST_ONE_SHOT: begin
            // Resolution latched at start; later writes wait their turn
            if (conv_done) begin
               d.res.word  = formatted; // [RULE8]
               d.res.ready = 1'b1; // [RULE8]
               d.cnt       = '0;
               d.st        = temp_conv_pkg::ST_STANDBY; // [RULE5]
            end else begin
               d.cnt = q.cnt + `CNT_W'(1); // [RULE7]
            end
         end
         default: begin
            d.st = temp_conv_pkg::ST_POWER_UP;
         end
      endcase

      d.sda_out = 1'b0;
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         q            <= '0;
         q.meta       <= '{scl: 1'b1, sda: 1'b1};
         q.sync       <= '{scl: 1'b1, sda: 1'b1};
         q.prev       <= '{scl: 1'b1, sda: 1'b1};
         q.st         <= temp_conv_pkg::ST_POWER_UP;
         q.res_lat    <= `RES_RESET_VALUE; // [RULE10]
         q.res.word   <= `TEMP_RESET_VALUE; // [RULE4]
         q.res.ready  <= 1'b0;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------
   // Link side
   // ----------------------------------------
   // Frame flag doubles as the link reset: it releases data at once
   serial_shift_out u_shift (
      .smb_clk    (smb_clk),
      .link_rst_n (q.frame),
      .word       (q.snap),
      .sda_oe     (sda_oe) // [RULE1]
   );

   assign sda_out            = q.sda_out;
   assign temperature_result = q.res.word; // [RULE14]
   assign result_ready_flag  = q.res.ready;
   assign link_functional    = q.functional;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking

   default disable iff (!rst_n);

   AST_TIMEOUT_RELEASE: assert property ( // [RULE1]
      (~q.sync.scl | ~q.sync.sda) && q.idle_cnt == `CNT_W'(TIMEOUT_CYC - 1)
      |=> !q.frame
   ) else $error("bus timeout did not drop the frame");

   AST_POR_FUNCTIONAL: assert property ( // [RULE2]
      q.st == temp_conv_pkg::ST_POWER_UP && q.cnt == `CNT_W'(POR_CYC - 3)
      |=> q.functional && q.st == temp_conv_pkg::ST_CONVERT && q.cnt == '0
   ) else $error("interface not functional after power-up wait");

   AST_FIRST_RESULT: assert property ( // [RULE3]
      q.st == temp_conv_pkg::ST_CONVERT && conv_done
      |=> q.res.ready && q.res.word == $past(formatted)
   ) else $error("conversion end did not load the result");

   AST_RESET_HOLD: assert property ( // [RULE4]
      q.st == temp_conv_pkg::ST_POWER_UP
      |-> q.res.word == `TEMP_RESET_VALUE && !q.res.ready && !q.functional
   ) else $error("reset value changed before first conversion");

   AST_ONESHOT_START: assert property ( // [RULE5]
      q.st == temp_conv_pkg::ST_STANDBY && shutdown && one_shot_req
      |=> q.st == temp_conv_pkg::ST_ONE_SHOT ##1
          q.st == temp_conv_pkg::ST_ONE_SHOT
   ) else $error("one-shot request not started");

   AST_ONESHOT_PENDING: assert property ( // [RULE6]
      q.st == temp_conv_pkg::ST_ONE_SHOT
      |-> q.res.word == `TEMP_PENDING_VALUE && !q.res.ready
   ) else $error("pending one-shot shows wrong result or flag");

   AST_ONESHOT_STABLE: assert property ( // [RULE7]
      q.st == temp_conv_pkg::ST_ONE_SHOT && !conv_done
      |=> $stable(q.res_lat) && $stable(q.functional)
   ) else $error("state changed during pending one-shot");

   AST_ONESHOT_DONE: assert property ( // [RULE8]
      q.st == temp_conv_pkg::ST_ONE_SHOT && conv_done
      |=> q.res.ready && q.res.word == $past(formatted)
          && q.st == temp_conv_pkg::ST_STANDBY
   ) else $error("one-shot end did not set flag and result");

   AST_LOW_BITS_ZERO: assert property ( // [RULE13]
      conv_done |=> (q.res.word & ~res_mask($past(q.res_lat))) == '0
   ) else $error("bits below resolution not zero");

   AST_SIGN_TOP: assert property ( // [RULE12]
      conv_done |=> q.res.word[`TEMP_SIGN_BIT] == $past(adc_code[ADC_W-1])
   ) else $error("sign not in top bit");

   AST_IGNORE_REQ: assert property ( // [RULE15]
      q.st == temp_conv_pkg::ST_CONVERT && one_shot_req && !conv_done
      |=> q.st == temp_conv_pkg::ST_CONVERT && q.cnt == $past(q.cnt) + 1'b1
   ) else $error("one-shot request disturbed continuous conversion");

   AST_RES_DEFAULT: assert property ( // [RULE10]
      q.st == temp_conv_pkg::ST_POWER_UP |-> q.res_lat == `RES_RESET_VALUE
   ) else $error("resolution not at its reset value");

   AST_CONT_RESAMPLE: assert property ( // [RULE9]
      q.st == temp_conv_pkg::ST_CONVERT && conv_done
      |=> q.res_lat == $past(res_sel)
   ) else $error("resolution not taken at conversion start");

   AST_ONESHOT_ENTRY: assert property ( // [RULE15]
      q.st == temp_conv_pkg::ST_ONE_SHOT
      |-> $past(q.st) == temp_conv_pkg::ST_ONE_SHOT
          || $past(q.st) == temp_conv_pkg::ST_STANDBY
   ) else $error("one-shot entered from outside standby");

   AST_RESULT_STANDS: assert property ( // [RULE14]
      q.st == temp_conv_pkg::ST_STANDBY && !one_shot_req
      |=> $stable(q.res.word)
   ) else $error("result changed while idle in standby");

   AST_READY_HELD: assert property ( // [RULE8]
      q.res.ready
      && !(q.st == temp_conv_pkg::ST_STANDBY && shutdown && one_shot_req)
      |=> q.res.ready
   ) else $error("ready flag dropped without a one-shot start");

   AST_LINK_QUIET: assert property ( // [RULE1]
      !q.frame |-> !sda_oe
   ) else $error("data line driven outside a frame");

   COV_ONESHOT: cover property (
      q.st == temp_conv_pkg::ST_ONE_SHOT ##1 q.st == temp_conv_pkg::ST_STANDBY
   );

   COV_TIMEOUT: cover property (
      q.frame ##1 !q.frame && q.idle_cnt == `CNT_W'(TIMEOUT_CYC - 1)
   );

   COV_FRAME: cover property (
      $rose(q.frame)
   );

   COV_CONT_DONE: cover property (
      q.st == temp_conv_pkg::ST_CONVERT && conv_done && !shutdown
   );

   COV_RES14_ONESHOT: cover property (
      q.st == temp_conv_pkg::ST_ONE_SHOT && q.res_lat == 2'h3
   );

endmodule // temp_sensor_conversion_core

// ---- verification/smb_host_model.sv ----
`timescale 1ns/100ps

// ----------------------------------------
// Host side of the two-wire link
// ----------------------------------------
module smb_host_model (
   output logic           scl,
   output logic           sda_low,
   input  wire logic      sda_line
);
   // Clock idles high between frames; data line is open drain
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task start_frame;
      // Offset keeps link edges clear of system clock edges
      #7;
      sda_low = 1'b1;
      #200;
   endtask

   task clk_low;
      scl = 1'b0;
      #20;
   endtask

   task stop_frame;
      scl = 1'b0;
      sda_low = 1'b1;
      #20;
      scl = 1'b1;
      #40;
      sda_low = 1'b0;
      #1300;
   endtask

   task read_word(output logic [15:0] w);
      start_frame();
      for (int i = 15; i >= 0; i--) begin
         clk_low();
         // Released only while clock low, so never seen as a stop
         sda_low = 1'b0;
         #20;
         scl = 1'b1;
         #20;
         w[i] = sda_line;
         #20;
      end
      stop_frame();
   endtask
endmodule // smb_host_model

// ---- verification/tb.sv ----
`timescale 1ns/100ps

module tb;
   logic        sys_clk;
   logic        resetn;
   logic        shutdown;
   logic        one_shot_req;
   logic        res_hi;
   logic        res_lo;
   logic [13:0] adc_code;
   logic [15:0] temp_word;
   logic [15:0] w;
   logic [15:0] exp_w;
   logic        ready;
   logic        live;
   logic        sda_oe;
   logic        sda_out_w;
   logic        scl;
   logic        host_low;
   wire         sda_line = ~(sda_oe | host_low);
   int          fails;
   int          num_checks;
   int          n;
   logic [15:0] masks [4] = '{16'hFFE0, 16'hFFF0, 16'hFFF8, 16'hFFFC};
   logic [13:0] codes [4] = '{14'h3ABC, 14'h2001, 14'h0199, 14'h1FFF};

   // ----------------------------------------
   // Design and host
   // ----------------------------------------
   temp_sensor_conversion_core #(
      // Timeout above the longest low run of a full 16-bit frame
      .TIMEOUT_CYC(100), .CONV11_CYC(30), .CONV12_CYC(40), .CONV13_CYC(50), .CONV14_CYC(60)
   ) u_temp_sensor_conversion_core (
      .sys_clk(sys_clk), .resetn(resetn), .smb_clk(scl), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out_w), .sda_oe(sda_oe), .shutdown(shutdown), .one_shot_req(one_shot_req),
      .resolution_select_high(res_hi), .resolution_select_low(res_lo), .adc_code(adc_code),
      .temperature_result(temp_word), .result_ready_flag(ready), .link_functional(live)
   );

   smb_host_model u_host (.scl(scl), .sda_low(host_low), .sda_line(sda_line));

   initial sys_clk = 1'b0;
   always #10 sys_clk = ~sys_clk;

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task tick;
      @(posedge sys_clk);
      #1;
   endtask

   task end_sim;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Resolution settles one edge before the request, as it is latched at start
   task one_shot(input int r);
      @(posedge sys_clk);
      {res_hi, res_lo} <= r[1:0];
      adc_code <= codes[r];
      @(posedge sys_clk);
      one_shot_req <= 1'b1;
      @(posedge sys_clk);
      one_shot_req <= 1'b0;
      #1;
      n = 0;
      while (ready !== 1'b0 && n < 4) begin
         tick();
         n++;
      end
      check(live, 1'b1);
      n = 0;
      while (ready === 1'b0 && n < 200) begin
         check(temp_word, 16'h8000);
         tick();
         n++;
      end
      exp_w = {codes[r], 2'b00} & masks[r];
      check(16'(n), 16'(30 + 10 * r));
      check(ready, 1'b1);
      check(temp_word, exp_w);
      u_host.read_word(w);
      check(w, exp_w);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      fails = 0;
      num_checks = 0;
      resetn = 1'b0;
      shutdown = 1'b1;
      one_shot_req = 1'b0;
      res_hi = 1'b0;
      res_lo = 1'b0;
      adc_code = 14'h0320;
      repeat (8) @(posedge sys_clk);
      check(temp_word, 16'h0000);
      check(live, 1'b0);
      check(sda_out_w, 1'b0);
      resetn <= 1'b1;
      n = 0;
      while (live !== 1'b1 && n < 60000) begin
         tick();
         n++;
      end
      // Counted from the release edge; 50000 cycles make 1 ms
      check(n <= 50000, 1'b1);
      n = 0;
      while (ready !== 1'b1 && n < 100) begin
         check(temp_word, 16'h0000);
         tick();
         n++;
      end
      check(n >= 29 && n <= 31, 1'b1);
      check(temp_word, 16'h0C80);
      for (int r = 0; r < 4; r++) begin
         one_shot(r);
      end
      // Stuck clock mid frame; last word is positive so bit 15 pulls low
      u_host.start_frame();
      u_host.clk_low();
      repeat (3) tick();
      check(sda_oe, 1'b1);
      repeat (70) tick();
      check(sda_oe, 1'b1);
      repeat (30) tick();
      check(sda_oe, 1'b0);
      check(sda_out_w, 1'b0);
      u_host.stop_frame();
      @(posedge sys_clk);
      shutdown <= 1'b0;
      repeat (5) @(posedge sys_clk);
      one_shot_req <= 1'b1;
      @(posedge sys_clk);
      one_shot_req <= 1'b0;
      repeat (3) tick();
      check(ready, 1'b1);
      check(temp_word, exp_w);
      u_host.read_word(w);
      check(w, exp_w);
      // Continuous mode must pick up a new negative code
      @(posedge sys_clk);
      adc_code <= 14'h3F00;
      repeat (130) tick();
      check(temp_word, 16'hFC00);
      check(ready, 1'b1);
      end_sim();
   end

   // Tests take about 51000 cycles, most of it the power-up wait
   initial begin
      #1100000;
      fails++;
      end_sim();
   end
endmodule // tb
